// ==== logic/rtc_bcd_inc.sv ====
// BCD two-digit incrementer with wrap to a low bound
`default_nettype none
module rtc_bcd_inc (
	input wire logic [7:0] val,
	input wire logic [7:0] last,
	input wire logic [7:0] first,
	output logic [7:0] nxt,
	output logic wrap
);
	always_comb begin
		wrap = (val == last);
		if (wrap) begin
			nxt = first;
		end else if (val[3:0] >= 4'h9) begin
			nxt = {val[7:4] + 4'h1, 4'h0};
		end else begin
			nxt = {val[7:4], val[3:0] + 4'h1};
		end
	end
endmodule : rtc_bcd_inc
`default_nettype wire

// ==== logic/rtc_pkg.sv ====
// Types shared by the time and date counter block
`default_nettype none
package rtc_pkg;
	typedef struct packed {
		logic [7:0] sec;
		logic [7:0] min;
		logic [7:0] hour;
		logic [7:0] day;
		logic [7:0] wday;
		logic [7:0] mon;
		logic [7:0] year;
	} rtc_time_t;
	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [7:0] data;
	} rtc_wr_t;
endpackage : rtc_pkg
`default_nettype wire

// ==== logic/rtc_tick_hold.sv ====
// Holds one tick that lands while a host access is in progress
`default_nettype none
module rtc_tick_hold (
	input wire logic clk,
	input wire logic rstn,
	input wire logic tick,
	input wire logic busy,
	output logic advance
);
	logic pend_q;
	always_ff @(posedge clk) begin
		if (!rstn) begin
			pend_q <= 1'b0;
		end else if (busy) begin
			if (tick) begin
				pend_q <= 1'b1;
			end
		end else begin
			pend_q <= 1'b0;
		end
	end
	assign advance = !busy && (tick || pend_q);
endmodule : rtc_tick_hold
`default_nettype wire

// ==== logic/rtc_time_date.sv ====
// Time of day and calendar counters with host register access
// Notes on behaviour
// - seconds BCD 00..59, bits 6:4 and 3:0
// - minutes at 04h, BCD 00..59
// - unimplemented bits read back zero
// - counters not cleared by any reset
// - 24-hour hours 00..23 at 05h
// - 12-hour hours 1..12, bit5 afternoon
// - format chosen by hour-format select bit
// - day of month 1..31 at 06h
// - February 29 when year divisible by four
// - weekday 0..6 at 07h bits 2:0
// - code 000 Sunday, 001 Monday
// - month 1..12 at 08h bits 4:0
// - integrity flag set by reset, host clears
// - year 00..99 BCD at 09h
// - counters frozen during host access
// - one tick held, access under second
`include "rtc_time_map.svh"
`default_nettype none
module rtc_time_date (
	input wire logic clk,
	input wire logic rstn,
	input wire logic tick_1hz,
	input wire logic access_busy,
	input wire logic mode_12h,
	input wire logic reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic clock_integrity_flag,
	output rtc_pkg::rtc_time_t time_now
);
	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	rtc_pkg::rtc_time_t t_q;
	rtc_pkg::rtc_time_t t_d;
	rtc_pkg::rtc_wr_t wr;
	logic integ_q;
	logic advance;
	logic afternoon_indicator;

	assign wr = '{wr: reg_wr, addr: reg_addr, data: reg_wdata};

	rtc_tick_hold u_hold (
		.clk(clk),
		.rstn(rstn),
		.tick(tick_1hz),
		.busy(access_busy),
		.advance(advance)
	);

	// ------------------------------------------------------------
	// Calendar helpers
	// ------------------------------------------------------------
	// leap year test
	function automatic logic leap(input logic [7:0] y);
		// BCD value divisible by four: tens even needs units 0,4,8; tens odd 2,6
		if (y[4] == 1'b0) begin
			leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
		end else begin
			leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
		end
	endfunction : leap

	function automatic logic [7:0] month_last(input logic [7:0] m, input logic lp);
		if (m == 8'h02) begin
			month_last = lp ? 8'h29 : 8'h28;
		end else if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11) begin
			month_last = 8'h30;
		end else begin
			month_last = 8'h31;
		end
	endfunction : month_last

	// ------------------------------------------------------------
	// Increment chain
	// ------------------------------------------------------------
	logic [7:0] sec_n, min_n, h24_n, day_n, mon_n, yr_n;
	logic sec_w, min_w, h24_w, day_w, mon_w;
	logic [7:0] hour_n;
	logic hour_w;
	logic [4:0] h12;

	rtc_bcd_inc u_sec (.val(t_q.sec & `RTC_SEC_MASK), .last(8'h59), .first(8'h00),
		.nxt(sec_n), .wrap(sec_w));
	rtc_bcd_inc u_min (.val(t_q.min), .last(8'h59), .first(8'h00),
		.nxt(min_n), .wrap(min_w));
	rtc_bcd_inc u_h24 (.val(t_q.hour), .last(8'h23), .first(8'h00),
		.nxt(h24_n), .wrap(h24_w));
	rtc_bcd_inc u_day (.val(t_q.day), .last(month_last(t_q.mon, leap(t_q.year))),
		.first(8'h01), .nxt(day_n), .wrap(day_w));
	rtc_bcd_inc u_mon (.val(t_q.mon), .last(8'h12), .first(8'h01),
		.nxt(mon_n), .wrap(mon_w));
	rtc_bcd_inc u_yr (.val(t_q.year), .last(8'h99), .first(8'h00),
		.nxt(yr_n), .wrap());

	assign h12 = t_q.hour[4:0];
	assign afternoon_indicator = t_q.hour[`RTC_AFTERNOON_BIT];

	always_comb begin
		hour_n = h24_n;
		hour_w = h24_w;
		if (mode_12h) begin
			hour_w = 1'b0;
			// afternoon toggles at 11 to 12
			if (h12 == 5'h11) begin
				hour_n = {2'b00, !afternoon_indicator, 5'h12};
				hour_w = afternoon_indicator;
			end else if (h12 == 5'h12) begin
				hour_n = {2'b00, afternoon_indicator, 5'h01};
			end else if (h12[3:0] >= 4'h9) begin
				hour_n = {2'b00, afternoon_indicator, 5'h10};
			end else begin
				hour_n = {2'b00, afternoon_indicator, h12[4], h12[3:0] + 4'h1};
			end
		end
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		t_d = t_q;
		if (advance) begin
			t_d.sec = sec_n;
			if (sec_w) begin
				t_d.min = min_n;
				if (min_w) begin
					t_d.hour = hour_n;
					if (hour_w) begin
						t_d.day = day_n;
						// week runs Sunday 0 to Saturday 6
						t_d.wday = (t_q.wday[2:0] >= 3'h6) ? 8'h00 : {5'h00, t_q.wday[2:0] + 3'h1};
						if (day_w) begin
							t_d.mon = mon_n;
							if (mon_w) begin
								t_d.year = yr_n;
							end
						end
					end
				end
			end
		end
		if (wr.wr) begin
			if (wr.addr == `RTC_ADDR_SECONDS) begin
				t_d.sec = wr.data & `RTC_SEC_MASK;
			end else if (wr.addr == `RTC_ADDR_MINUTES) begin
				t_d.min = wr.data & `RTC_MIN_MASK;
			end else if (wr.addr == `RTC_ADDR_HOURS) begin
				t_d.hour = wr.data & `RTC_HOUR_MASK;
			end else if (wr.addr == `RTC_ADDR_DAYS) begin
				t_d.day = wr.data & `RTC_DAY_MASK;
			end else if (wr.addr == `RTC_ADDR_WEEKDAYS) begin
				t_d.wday = wr.data & `RTC_WDAY_MASK;
			end else if (wr.addr == `RTC_ADDR_MONTHS) begin
				t_d.mon = wr.data & `RTC_MON_MASK;
			end else if (wr.addr == `RTC_ADDR_YEARS) begin
				t_d.year = wr.data & `RTC_YEAR_MASK;
			end
		end
	end

	always_ff @(posedge clk) begin
		t_q <= t_d;
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			integ_q <= `RTC_INTEGRITY_RST;
		end else if (wr.wr && wr.addr == `RTC_ADDR_SECONDS) begin
			integ_q <= wr.data[`RTC_INTEGRITY_BIT];
		end
	end

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	// reserved bits read zero
	always_ff @(posedge clk) begin
		if (!rstn) begin
			reg_rdata <= 8'h00;
		end else if (reg_addr == `RTC_ADDR_SECONDS) begin
			reg_rdata <= {integ_q, t_q.sec[6:0]};
		end else if (reg_addr == `RTC_ADDR_MINUTES) begin
			reg_rdata <= t_q.min & `RTC_MIN_MASK;
		end else if (reg_addr == `RTC_ADDR_HOURS) begin
			reg_rdata <= t_q.hour & `RTC_HOUR_MASK;
		end else if (reg_addr == `RTC_ADDR_DAYS) begin
			reg_rdata <= t_q.day & `RTC_DAY_MASK;
		end else if (reg_addr == `RTC_ADDR_WEEKDAYS) begin
			reg_rdata <= t_q.wday & `RTC_WDAY_MASK;
		end else if (reg_addr == `RTC_ADDR_MONTHS) begin
			reg_rdata <= t_q.mon & `RTC_MON_MASK;
		end else if (reg_addr == `RTC_ADDR_YEARS) begin
			reg_rdata <= t_q.year;
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	assign clock_integrity_flag = integ_q;
	assign time_now = t_q;
endmodule : rtc_time_date
`default_nettype wire

// ==== logic/rtc_time_map.svh ====
// Register offsets, field positions and constants of the time and date counters
`ifndef RTC_TIME_MAP_SVH
`define RTC_TIME_MAP_SVH
`define RTC_ADDR_SECONDS 8'h03
`define RTC_ADDR_MINUTES 8'h04
`define RTC_ADDR_HOURS 8'h05
`define RTC_ADDR_DAYS 8'h06
`define RTC_ADDR_WEEKDAYS 8'h07
`define RTC_ADDR_MONTHS 8'h08
`define RTC_ADDR_YEARS 8'h09
`define RTC_SEC_MASK 8'h7F
`define RTC_MIN_MASK 8'h7F
`define RTC_HOUR_MASK 8'h3F
`define RTC_DAY_MASK 8'h3F
`define RTC_WDAY_MASK 8'h07
`define RTC_MON_MASK 8'h1F
`define RTC_YEAR_MASK 8'hFF
`define RTC_INTEGRITY_BIT 7
`define RTC_AFTERNOON_BIT 5
`define RTC_INTEGRITY_RST 1'h1
`endif

// ==== verif/rtc_host_model.sv ====
// Host model driving the register port of the counters
`default_nettype none
module rtc_host_model (
	input wire logic clk,
	input wire logic [7:0] reg_rdata,
	output logic access_busy,
	output logic reg_wr,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		access_busy = 1'b0;
		reg_wr = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk);
		reg_wr = 1'b0;
		reg_wdata = ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		@(negedge clk);
		d = reg_rdata;
	endtask : rd
	task automatic hold(input int n);
		@(negedge clk);
		access_busy = 1'b1;
		repeat (n) @(negedge clk);
		access_busy = 1'b0;
	endtask : hold
endmodule : rtc_host_model
`default_nettype wire

// ==== verif/rtc_time_date_assertions.sv ====
// Checker for the time and date counter block
`default_nettype none
module rtc_time_date_assertions (
	input wire logic clk,
	input wire logic rstn,
	input wire logic tick_1hz,
	input wire logic access_busy,
	input wire logic reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic clock_integrity_flag,
	input wire rtc_pkg::rtc_time_t time_now
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	wire adv = tick_1hz && !access_busy && !reg_wr;
	wday_zero_a:
		assert property (reg_addr == 8'h07 |=> reg_rdata[7:3] == 5'h00) else $error("wday bits");
	min_store_a:
		assert property (reg_wr && reg_addr == 8'h04 |=> time_now.min == ($past(reg_wdata) & 8'h7F))
		else $error("min write");
	hour_store_a:
		assert property (reg_wr && reg_addr == 8'h05 |=> time_now.hour == ($past(reg_wdata) & 8'h3F))
		else $error("hour write");
	flag_set_a:
		assert property (disable iff (1'b0) !rstn |=> clock_integrity_flag) else $error("flag");
	keep_time_a:
		assert property (disable iff (1'b0) !rstn && !reg_wr && time_now.year <= 8'h99
			|=> $stable({time_now.sec[6:0], time_now[47:0]})) else $error("reset hit time");
	busy_freeze_a:
		assert property (access_busy && !reg_wr |=> $stable(time_now)) else $error("busy moved");
	sec_step_a:
		assert property (adv && time_now.sec[3:0] < 4'h9
			|=> time_now.sec[3:0] == $past(time_now.sec[3:0]) + 4'h1) else $error("sec step");
	sec_wrap_a:
		assert property (adv && time_now.sec[6:0] == 7'h59 |=> time_now.sec[6:0] == 7'h00)
		else $error("sec wrap");
endmodule : rtc_time_date_assertions
bind rtc_time_date rtc_time_date_assertions chk (.clk, .rstn, .tick_1hz, .access_busy, .reg_wr,
	.reg_addr, .reg_wdata, .reg_rdata, .clock_integrity_flag, .time_now);
`default_nettype wire

// ==== verif/test_rtc_time_date.sv ====
// Self-checking bench for the time and date counters
`default_nettype none
module test_rtc_time_date;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic tick_1hz = 1'b0;
	logic mode_12h = 1'b0;
	logic access_busy, reg_wr, clock_integrity_flag;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, rv, a, d;
	rtc_pkg::rtc_time_t time_now;
	int bad_count = 0;
	int checks_done = 0;
	int seed = 92926;
	// Start time, time one tick later, hour format
	localparam logic [112:0] corners [7] = '{
		{56'h59_59_23_31_06_12_99, 56'h00_00_00_01_00_01_00, 1'h0},
		{56'h59_59_23_28_02_02_24, 56'h00_00_00_29_03_02_24, 1'h0},
		{56'h59_59_23_29_03_02_00, 56'h00_00_00_01_04_03_00, 1'h0},
		{56'h59_59_23_28_01_02_23, 56'h00_00_00_01_02_03_23, 1'h0},
		{56'h59_59_11_05_01_07_10, 56'h00_00_32_05_01_07_10, 1'h1},
		{56'h59_59_32_05_01_07_10, 56'h00_00_21_05_01_07_10, 1'h1},
		{56'h59_59_31_05_01_07_10, 56'h00_00_12_06_02_07_10, 1'h1}};
	localparam logic [63:0] masks = 64'h00_FF_1F_07_3F_3F_7F_FF;
	always #2.5 clk = ~clk;
	rtc_host_model host (.clk, .reg_rdata, .access_busy, .reg_wr, .reg_addr, .reg_wdata);
	rtc_time_date dut (.clk, .rstn, .tick_1hz, .access_busy, .mode_12h, .reg_wr, .reg_addr,
		.reg_wdata, .reg_rdata, .clock_integrity_flag, .time_now);
	function automatic logic [7:0] bcd(input logic [7:0] v);
		return ((v / 8'h0A) << 4) | (v % 8'h0A);
	endfunction : bcd
	task automatic check(input logic [55:0] got, input logic [55:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : check
	task automatic set_time(input logic [55:0] t);
		for (int i = 0; i < 7; i++) host.wr(8'h03 + 8'(i), t[55 - 8 * i -: 8]);
	endtask : set_time
	task automatic pulse;
		@(negedge clk);
		tick_1hz = 1'b1;
		@(negedge clk);
		tick_1hz = 1'b0;
	endtask : pulse
	task automatic conclude;
		if (bad_count == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : conclude
	// ------------------------------
	// Main sequence
	// ------------------------------
	initial begin
		repeat (5) @(negedge clk);
		rstn = 1'b1;
		for (int i = 0; i < 7; i++) begin
			mode_12h = corners[i][0];
			set_time(corners[i][112:57]);
			pulse();
			check(time_now & 56'h7F_FF_FF_FF_FF_FF_FF, corners[i][56:1]);
		end
		repeat (24) begin
			a = 8'h03 + 8'($unsigned($random(seed)) % 8);
			d = 8'($random(seed));
			host.wr(a, d);
			host.rd(a, rv);
			check(56'(rv), 56'(d & masks[8 * (a - 8'h03) +: 8]));
		end
		repeat (8) begin
			d = 8'($unsigned($random(seed)) % 59);
			host.wr(8'h03, bcd(d));
			pulse();
			check(56'(time_now.sec), 56'(bcd(d + 8'h01)));
		end
		host.wr(8'h03, 8'h10);
		fork
			host.hold(12);
			begin
				repeat (3) @(negedge clk);
				pulse();
				pulse();
			end
		join
		@(negedge clk);
		check(56'(time_now.sec), 56'h11);
		rstn = 1'b0;
		@(negedge clk);
		rstn = 1'b1;
		check(56'(clock_integrity_flag), 56'h1);
		check(56'(time_now.sec[6:0]), 56'h11);
		host.wr(8'h03, 8'h11);
		check(56'(clock_integrity_flag), 56'h0);
		conclude();
	end
	initial begin
		#50us;
		bad_count++;
		conclude();
	end
endmodule : test_rtc_time_date
`default_nettype wire
